// >>> pkg/i2rd_defs.vh
// Constants for the register-read serial target
// What this block does
// - Target acknowledges its own address and the pointer byte by pulling data low.
// - Target shifts out eight bits from the register the pointer selects.
// - Controller acknowledge asks for more; target supplies the next sequential register.
// - STOP returns the input filters to slow setting; repeated START keeps them.
// - Target not-acknowledges the master code and selects the fast filter setting.
// - Fast transfers continue until STOP returns the slow filter setting.
// - With extension enabled, fast operation is kept across STOP.
// - Extension enable is set only from slow mode; a fast-mode set is ignored.
// - Target never holds the clock line low.
`ifndef I2RD_DEFS_VH
`define I2RD_DEFS_VH

`define I2RD_ADDR_SERIAL_CFG  8'h15
`define I2RD_CFG_EXT_BIT      0
`define I2RD_CFG_RESET        8'h00
`define I2RD_TARGET_ADDR      7'h69
`define I2RD_MCODE_HI         5'b00001
`define I2RD_BITS_PER_BYTE    4'h8

`define I2RD_ST_IDLE          3'h0
`define I2RD_ST_RX            3'h1
`define I2RD_ST_RXACK         3'h2
`define I2RD_ST_TX            3'h3
`define I2RD_ST_TXACK         3'h4

`define I2RD_KIND_ADDR        2'h0
`define I2RD_KIND_PTR         2'h1
`define I2RD_KIND_DATA        2'h2

`endif

// >>> rtl/i2rd_fifo.v
// Synchronous FIFO with registered output stage
`timescale 1ns/1ps
`default_nettype none
module i2rd_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk,
    input  wire             resetn,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output reg              out_valid,
    input  wire             out_ready,
    output reg  [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_idx;
    reg [AW-1:0]    rd_idx;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    // Full when storage holds DEPTH words
    assign in_ready = (count != DEPTH[AW:0]);
    assign push     = in_valid && in_ready;
    assign pop      = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready);

    // Storage write
    always @(posedge clk) begin
        if (push) begin
            mem[wr_idx] <= in_data;
        end
    end

    // Pointers, count and output stage
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_idx    <= {AW{1'b0}};
            rd_idx    <= {AW{1'b0}};
            count     <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data  <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wr_idx <= (wr_idx == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_idx + 1'b1;
            end
            if (pop) begin
                rd_idx   <= (rd_idx == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_idx + 1'b1;
                out_data <= mem[rd_idx];
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
            if (pop) begin
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> rtl/i2rd_target.v
// Serial register-read target with fast-mode filter control
`timescale 1ns/1ps
`default_nettype none
`include "i2rd_defs.vh"
module i2rd_target #(
    parameter [6:0] TARGET_ADDR = `I2RD_TARGET_ADDR,
    parameter       FIFO_DEPTH  = 16
) (
    input  wire       clk,
    input  wire       resetn,
    input  wire       scl_in,
    output reg        scl_out,
    output reg        scl_oe,
    input  wire       sda_in,
    output reg        sda_out,
    output reg        sda_oe,
    output reg        fast_filter_sel,
    output reg        fast_mode_extension_enable,
    output reg  [7:0] rd_addr,
    input  wire [7:0] rd_data,
    output wire       wr_valid,
    input  wire       wr_ready,
    output wire [7:0] wr_addr,
    output wire [7:0] wr_data
);
    // Pin synchronisers and edge history
    reg        scl_s1;
    reg        scl_s2;
    reg        scl_s3;
    reg        sda_s1;
    reg        sda_s2;
    reg        sda_s3;
    wire       scl_rise;
    wire       scl_fall;
    wire       start_seen;
    wire       stop_seen;

    reg  [2:0] state;
    reg  [1:0] kind;
    reg  [3:0] bitcnt;
    reg  [7:0] shreg;
    reg  [7:0] ptr;
    reg        acked;
    reg        read_dir;
    reg        master_ack;
    reg  [7:0] serial_config;

    reg        push_valid;
    reg  [7:0] push_addr;
    reg  [7:0] push_data;
    wire       push_ready;
    wire [15:0] fifo_out;
    wire [7:0]  rd_byte;

    // Read mux: local config register or the outside register file
    function [7:0] i2rd_rd_mux;
        input [7:0] addr;
        input [7:0] cfg;
        input [7:0] ext;
        begin
            i2rd_rd_mux = (addr == `I2RD_ADDR_SERIAL_CFG) ? cfg : ext;
        end
    endfunction

    // Master code pattern 0000_1xx0
    function i2rd_is_mcode;
        input [7:0] b;
        begin
            i2rd_is_mcode = (b[7:3] == `I2RD_MCODE_HI) && !b[0];
        end
    endfunction

    assign scl_rise   = scl_s2 && !scl_s3;
    assign scl_fall   = !scl_s2 && scl_s3;
    assign start_seen = scl_s2 && scl_s3 && !sda_s2 && sda_s3;
    assign stop_seen  = scl_s2 && scl_s3 && sda_s2 && !sda_s3;
    assign wr_addr    = fifo_out[15:8];
    assign wr_data    = fifo_out[7:0];
    assign rd_byte    = i2rd_rd_mux(ptr, serial_config, rd_data); // Byte under the pointer

    // Two-stage synchronisers, then one history stage
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_s3 <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_s3 <= 1'b1;
        end else begin
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            scl_s3 <= scl_s2;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            sda_s3 <= sda_s2;
        end
    end

    // Clock line is never driven
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_out <= 1'b0;
            scl_oe  <= 1'b0;
        end else begin
            scl_out <= 1'b0;
            scl_oe  <= 1'b0;
        end
    end

    // Filter setting: fast on master code, slow on STOP unless extended
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fast_filter_sel <= 1'b0;
        end else if (stop_seen) begin
            if (!fast_mode_extension_enable) begin
                fast_filter_sel <= 1'b0;
            end
        end else if (scl_fall && state == `I2RD_ST_RX && bitcnt == `I2RD_BITS_PER_BYTE
                     && kind == `I2RD_KIND_ADDR && i2rd_is_mcode(shreg)) begin
            fast_filter_sel <= 1'b1;
        end
    end

    // Protocol engine
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state         <= `I2RD_ST_IDLE;
            kind          <= `I2RD_KIND_ADDR;
            bitcnt        <= 4'h0;
            shreg         <= 8'h00;
            ptr           <= 8'h00;
            acked         <= 1'b0;
            read_dir      <= 1'b0;
            master_ack    <= 1'b0;
            sda_out       <= 1'b0;
            sda_oe        <= 1'b0;
            rd_addr       <= 8'h00;
            serial_config <= `I2RD_CFG_RESET;
            fast_mode_extension_enable <= 1'b0;
            push_valid    <= 1'b0;
            push_addr     <= 8'h00;
            push_data     <= 8'h00;
        end else begin
            rd_addr <= ptr;
            if (push_valid && push_ready) begin
                push_valid <= 1'b0;
            end
            if (start_seen) begin
                // START or repeated START; filter setting untouched here
                state  <= `I2RD_ST_RX;
                kind   <= `I2RD_KIND_ADDR;
                bitcnt <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop_seen) begin
                state  <= `I2RD_ST_IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (state)
                    `I2RD_ST_RX: begin
                        if (scl_rise && bitcnt != `I2RD_BITS_PER_BYTE) begin
                            shreg  <= {shreg[6:0], sda_s2};
                            bitcnt <= bitcnt + 4'h1;
                        end else if (scl_fall && bitcnt == `I2RD_BITS_PER_BYTE) begin
                            state <= `I2RD_ST_RXACK;
                            acked <= 1'b0;
                            case (kind)
                                `I2RD_KIND_ADDR: begin
                                    if (shreg[7:1] == TARGET_ADDR) begin
                                        acked    <= 1'b1;
                                        sda_oe   <= 1'b1;
                                        read_dir <= shreg[0];
                                    end else if (!i2rd_is_mcode(shreg)) begin
                                        state <= `I2RD_ST_IDLE;
                                    end
                                end
                                `I2RD_KIND_PTR: begin
                                    ptr    <= shreg;
                                    acked  <= 1'b1;
                                    sda_oe <= 1'b1;
                                end
                                `I2RD_KIND_DATA: begin
                                    if (!push_valid) begin
                                        acked      <= 1'b1;
                                        sda_oe     <= 1'b1;
                                        push_valid <= 1'b1;
                                        push_addr  <= ptr;
                                        push_data  <= shreg;
                                        ptr        <= ptr + 8'h01;
                                        if (ptr == `I2RD_ADDR_SERIAL_CFG) begin
                                            serial_config <= shreg;
                                            if (!fast_filter_sel) begin
                                                fast_mode_extension_enable <=
                                                    shreg[`I2RD_CFG_EXT_BIT];
                                            end
                                        end
                                    end
                                end
                                default: begin
                                    state <= `I2RD_ST_IDLE;
                                end
                            endcase
                        end
                    end
                    `I2RD_ST_RXACK: begin
                        if (scl_fall) begin
                            sda_oe <= 1'b0;
                            bitcnt <= 4'h0;
                            if (!acked) begin
                                state <= `I2RD_ST_IDLE;
                            end else if (kind == `I2RD_KIND_ADDR && read_dir) begin
                                // First read byte from the pointer
                                state  <= `I2RD_ST_TX;
                                shreg  <= rd_byte;
                                sda_oe <= !rd_byte[7];
                                ptr    <= ptr + 8'h01;
                            end else begin
                                state <= `I2RD_ST_RX;
                                kind  <= (kind == `I2RD_KIND_ADDR) ? `I2RD_KIND_PTR
                                                                   : `I2RD_KIND_DATA;
                            end
                        end
                    end
                    `I2RD_ST_TX: begin
                        if (scl_rise) begin
                            bitcnt <= bitcnt + 4'h1;
                        end else if (scl_fall) begin
                            if (bitcnt == `I2RD_BITS_PER_BYTE) begin
                                sda_oe <= 1'b0;
                                state  <= `I2RD_ST_TXACK;
                            end else begin
                                shreg  <= {shreg[6:0], 1'b0};
                                sda_oe <= !shreg[6];
                            end
                        end
                    end
                    `I2RD_ST_TXACK: begin
                        if (scl_rise) begin
                            master_ack <= !sda_s2;
                        end else if (scl_fall) begin
                            bitcnt <= 4'h0;
                            if (master_ack) begin
                                // Next sequential register
                                state  <= `I2RD_ST_TX;
                                shreg  <= rd_byte;
                                sda_oe <= !rd_byte[7];
                                ptr    <= ptr + 8'h01;
                            end else begin
                                state <= `I2RD_ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        state <= `I2RD_ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Write bytes queue toward the register owner
    i2rd_fifo #(
        .WIDTH (16),
        .DEPTH (FIFO_DEPTH),
        .AW    (4)
    ) u_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   ({push_addr, push_data}),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  (fifo_out)
    );
endmodule
`default_nettype wire

// >>> verif/i2rd_target_props.sv
// Concurrent checks on the serial target ports
`timescale 1ns/1ps
`default_nettype none
module i2rd_target_props (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       scl_oe,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic       fast_filter_sel,
    input wire logic       fast_mode_extension_enable,
    input wire logic       wr_valid,
    input wire logic       wr_ready,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_no_clock_hold: assert property (!scl_oe)
        else $error("clock line held low");
    chk_data_open_drain: assert property (sda_oe |-> !sda_out)
        else $error("data line driven high");
    chk_drive_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
        else $error("data changed while clock high");
    chk_stop_slow_filter: assert property (scl_in && $past(scl_in) && sda_in && !$past(sda_in)
        && !fast_mode_extension_enable |-> ##[1:8] !fast_filter_sel)
        else $error("filter not slow after stop");
    chk_ext_keeps_fast: assert property (scl_in && $past(scl_in) && sda_in && !$past(sda_in)
        && fast_mode_extension_enable && fast_filter_sel |=> fast_filter_sel[*8])
        else $error("fast lost across stop");
    chk_start_keeps_filter: assert property (scl_in && $past(scl_in) && !sda_in
        && $past(sda_in) && fast_filter_sel |=> fast_filter_sel[*8])
        else $error("filter changed on start");
    chk_ext_slow_only: assert property ($rose(fast_mode_extension_enable)
        |-> !$past(fast_filter_sel))
        else $error("extension set from fast mode");
    chk_fifo_word_hold: assert property (wr_valid && !wr_ready
        |=> wr_valid && $stable(wr_data) && $stable(wr_addr))
        else $error("stalled word changed");
endmodule
bind i2rd_target i2rd_target_props u_props (.clk(clk), .resetn(resetn), .scl_in(scl_in),
    .sda_in(sda_in), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
    .fast_filter_sel(fast_filter_sel),
    .fast_mode_extension_enable(fast_mode_extension_enable), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data));
`default_nettype wire

// >>> verif/i2rd_host_model.sv
// Behavioural bus controller driving the serial link
`timescale 1ns/1ps
`default_nettype none
module i2rd_host_model (
    input  wire logic clk,
    input  wire logic sda,
    output var  logic scl_h,
    output var  logic sda_h
);
    logic r;

    // Both lines released while idle
    initial begin
        scl_h = 1'b1;
        sda_h = 1'b1;
    end
    // One pulse: data set while low, sampled mid-high
    task automatic bit_cyc(input logic d, output logic q);
        sda_h = d;
        repeat (4) @(negedge clk);
        scl_h = 1'b1;
        repeat (2) @(negedge clk);
        q = sda;
        repeat (2) @(negedge clk);
        scl_h = 1'b0;
    endtask
    // Start or repeated start
    task automatic start();
        sda_h = 1'b1;
        repeat (4) @(negedge clk);
        scl_h = 1'b1;
        repeat (4) @(negedge clk);
        sda_h = 1'b0;
        repeat (4) @(negedge clk);
        scl_h = 1'b0;
    endtask
    // Stop, both lines then stay high
    task automatic stop();
        sda_h = 1'b0;
        repeat (4) @(negedge clk);
        scl_h = 1'b1;
        repeat (4) @(negedge clk);
        sda_h = 1'b1;
        repeat (4) @(negedge clk);
    endtask
    // Byte out, most significant first
    task automatic wr(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) bit_cyc(d[i], r);
        bit_cyc(1'b1, r);
        ack = ~r;
    endtask
    // Byte in, answered with ack when more wanted
    task automatic rd(input logic more, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) bit_cyc(1'b1, d[i]);
        bit_cyc(~more, r);
    endtask
endmodule
`default_nettype wire

// >>> verif/i2rd_target_test.sv
// Self-checking bench for the register-read serial target
`timescale 1ns/1ps
`default_nettype none
`include "i2rd_defs.vh"
module i2rd_target_test;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        wr_ready = 1'b0;
    logic [31:0] seed = 32'h00009a1f;
    logic [7:0]  regs [256];
    logic [7:0]  q [$];
    logic [7:0]  rd_addr, rd_data, wr_addr, wr_data, b, p, wa;
    logic        scl_oe, scl_out, sda_oe, sda_out, fast, ext, wr_valid, a;
    wire  logic  scl_h, sda_h;
    wire  logic  scl = scl_h & ~scl_oe;
    wire  logic  sda = sda_h & ~sda_oe;
    int          n_mismatch = 0;
    int          total_checks = 0;
    int          i, k, n;
    localparam logic [7:0] adr_w = {`I2RD_TARGET_ADDR, 1'b0};
    localparam logic [7:0] adr_r = {`I2RD_TARGET_ADDR, 1'b1};

    always #12.5 clk = ~clk;
    assign rd_data = regs[rd_addr];
    i2rd_host_model host (.clk(clk), .sda(sda), .scl_h(scl_h), .sda_h(sda_h));
    i2rd_target #(.FIFO_DEPTH(16)) dut (.clk(clk), .resetn(resetn), .scl_in(scl),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .fast_filter_sel(fast), .fast_mode_extension_enable(ext), .rd_addr(rd_addr),
        .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
        .wr_data(wr_data));

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (n_mismatch == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Address or byte with expected acknowledge
    task automatic adr(input logic [7:0] v, input logic e);
        host.wr(v, a);
        chk(8'(a), 8'(e));
    endtask
    // Pointer set, repeated start, then cnt bytes read
    task automatic rdseq(input logic [7:0] ptr, input int cnt);
        host.start();
        adr(adr_w, 1'b1);
        adr(ptr, 1'b1);
        host.start();
        adr(adr_r, 1'b1);
        for (int j = 0; j < cnt; j++) begin
            host.rd(j < cnt - 1, b);
            chk(b, regs[8'(ptr + j)]);
        end
    endtask
    // Master code with the don't-care pair set to xx
    task automatic mcode(input logic [1:0] xx);
        host.start();
        adr({`I2RD_MCODE_HI, xx, 1'b0}, 1'b0);
    endtask
    task automatic cfg(input logic [7:0] v);
        host.start();
        adr(adr_w, 1'b1);
        adr(`I2RD_ADDR_SERIAL_CFG, 1'b1);
        adr(v, 1'b1);
        host.stop();
    endtask

    // Main sequence
    initial begin
        for (i = 0; i < 256; i++) regs[i] = rnd();
        repeat (16) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        chk({6'h00, fast, ext}, 8'h00);
        chk({6'h00, scl_out, sda_out}, 8'h00);
        for (n = 1; n <= 4; n++) begin
            p = rnd() | 8'h80;
            rdseq(p, n);
            host.stop();
        end
        host.start();
        adr({7'h2a, 1'b0}, 1'b0);
        host.stop();
        // Every master code variant; Sr keeps fast, stop clears it
        for (i = 0; i < 4; i++) begin
            mcode(i[1:0]);
            rdseq(p, 2);
            chk(8'(fast), 8'h01);
            host.stop();
            chk(8'(fast), 8'h00);
        end
        // Writes pile up behind a stalled consumer until refused
        host.start();
        adr(adr_w, 1'b1);
        adr(8'h40, 1'b1);
        a = 1'b1;
        for (k = 0; k < 24 && a; k++) begin
            b = rnd();
            host.wr(b, a);
            if (a) q.push_back(b);
        end
        host.stop();
        chk(8'(a), 8'h00);
        chk(8'(q.size() >= 16), 8'h01);
        // Drain with a randomly stalling consumer
        wa = 8'h40;
        repeat (400) begin
            @(negedge clk);
            b = rnd();
            wr_ready = b[0];
            if (wr_valid === 1'b1 && b[0]) begin
                chk(wr_data, q.pop_front());
                chk(wr_addr, wa);
                wa++;
            end
        end
        chk(8'(q.size()), 8'h00);
        wr_ready = 1'b1;
        // Extension set from fast mode is ignored, from slow mode taken
        mcode(2'h0);
        cfg(8'h01);
        chk({6'h00, fast, ext}, 8'h00);
        cfg(8'h01);
        chk(8'(ext), 8'h01);
        // Config register reads back its own value, not the outside one
        regs[8'h15] = 8'hfe;
        host.start();
        adr(adr_w, 1'b1);
        adr(`I2RD_ADDR_SERIAL_CFG, 1'b1);
        host.start();
        adr(adr_r, 1'b1);
        host.rd(1'b0, b);
        chk(b, 8'h01);
        host.stop();
        mcode(2'h3);
        host.stop();
        rdseq(p, 3);
        host.stop();
        chk(8'(fast), 8'h01);
        complete_run();
    end
    // Watchdog against a hung link
    initial begin
        #2_000_000;
        n_mismatch++;
        complete_run();
    end
endmodule
`default_nettype wire
